// [design/anadv_lcw.sv]
`timescale 1ns/10ps
module anadv_lcw import anadv_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        speed_100,
	input  wire logic        duplex_full,
	input  wire logic        start,
	input  wire anadv_word_t adv,
	output logic [3:0]       pin_ability,
	output anadv_word_t      lcw_r
);

	// Strap decode: exactly one ability is offered in hardware mode.
	always_comb begin
		pin_ability = ABIL_10HD;
		unique case ({speed_100, duplex_full})
			2'b11: pin_ability = ABIL_100FD;
			2'b10: pin_ability = ABIL_100HD;
			2'b01: pin_ability = ABIL_10FD;
			2'b00: pin_ability = ABIL_10HD;
		endcase
	end

	// The word is frozen between starts so that a half-finished station
	// update never reaches the partner mid-exchange.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lcw_r <= anadv_word_t'(ADV_RESET);
		end else if (start) begin
			lcw_r     <= adv;
			lcw_r.ack <= 1'b0;
			lcw_r.rsv <= 3'h0;
			lcw_r.t4  <= 1'b0;
		end
	end

endmodule

// [design/anadv_pkg.sv]
package anadv_pkg;

	localparam logic [4:0]  ADV_REG_ADDR  = 5'h04;
	localparam logic [15:0] ADV_RESET     = 16'h01E1;
	localparam logic [4:0]  PHY_ADDR_DEF  = 5'h01;

	localparam int NP_BIT      = 15;
	localparam int RSV14_BIT   = 14;
	localparam int RF_BIT      = 13;
	localparam int RSV_HI_BIT  = 12;
	localparam int RSV_LO_BIT  = 10;
	localparam int ABIL_HI_BIT = 8;
	localparam int ABIL_LO_BIT = 5;
	localparam int SEL_HI_BIT  = 4;

	localparam logic [3:0] ABIL_ALL   = 4'hF;
	localparam logic [3:0] ABIL_100FD = 4'h8;
	localparam logic [3:0] ABIL_100HD = 4'h4;
	localparam logic [3:0] ABIL_10FD  = 4'h2;
	localparam logic [3:0] ABIL_10HD  = 4'h1;
	localparam logic [4:0] SEL_DEF    = 5'h01;

	localparam logic [5:0] PRE_ONES   = 6'h20;
	localparam logic [5:0] HDR_LAST   = 6'h0B;
	localparam logic [5:0] TA_LAST    = 6'h01;
	localparam logic [5:0] DATA_BITS  = 6'h10;
	localparam logic [5:0] DATA_LAST  = 6'h0F;
	localparam logic [1:0] OP_READ    = 2'h2;
	localparam logic [1:0] OP_WRITE   = 2'h1;

	typedef struct packed {
		logic       next_page;
		logic       ack;
		logic       remote_fault;
		logic [2:0] rsv;
		logic       t4;
		logic [3:0] technology_ability_field;
		logic [4:0] selector;
	} anadv_word_t;

	typedef enum logic [2:0] {
		MS_PRE   = 3'h0,
		MS_START = 3'h1,
		MS_HDR   = 3'h3,
		MS_TA    = 3'h2,
		MS_DATA  = 3'h6
	} anadv_mst_t;

endpackage

// [design/anadv_top.sv]
`timescale 1ns/10ps
module anadv_top import anadv_pkg::*; #(
	parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEF
) (
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	input  wire logic        MDC,
	input  wire logic        MDIO_I,
	output logic             MDIO_O,
	output logic             MDIO_OE,
	input  wire logic        MODE_SELECT_PIN_A,
	input  wire logic        AUTONEG_SELECT_PIN,
	input  wire logic        SPEED_SELECT_PIN,
	input  wire logic        DUPLEX_SELECT_PIN,
	input  wire logic        AN_ENABLE,
	input  wire logic        AN_RESTART,
	input  wire logic        CTRL_SPEED_100,
	input  wire logic        CTRL_DUPLEX_FULL,
	input  wire logic        CMD_OVERRIDE,
	input  wire logic        LINK_FAULT,
	output anadv_word_t      LINK_CODE_WORD,
	output logic             AN_ACTIVE,
	output logic             AN_START,
	output logic             FORCE_IDLE,
	output logic             FORCE_SPEED_100,
	output logic             FORCE_DUPLEX_FULL,
	output logic [3:0]       RSV_AUX,
	output logic [3:0]       STATUS_ABILITY
);

	// Advertisement register storage.
	logic        np_r;
	logic        rsv14_r;
	logic [2:0]  rsv_r;
	logic        rf_r;
	logic [3:0]  ability_r;
	logic [4:0]  sel_r;
	logic        fault_q_r;

	// Management frame engine.
	anadv_mst_t  mst_r;
	logic [5:0]  cnt_r;
	logic [15:0] shift_r;
	logic [15:0] rd_buf_r;
	logic        hit_r;
	logic        rd_drive_r;
	logic        mdc_q_r;
	logic        mdio_o_r;
	logic        mdio_oe_r;
	logic        wr_commit_r;
	logic [15:0] wr_data_r;

	// Negotiation control.
	logic        init_done_r;
	logic        an_on_r;
	logic        an_start_r;
	logic        force_idle_r;
	logic        force_spd_r;
	logic        force_dpx_r;
	logic [3:0]  status_ab_r;

	logic        mdc_rise;
	logic        mdc_fall;
	logic [11:0] hdr;
	logic        an_req;
	logic        ovr_wr;
	logic        fault_rise;
	logic        fault_fall;
	logic [3:0]  pin_ability;
	anadv_word_t adv_view;

	assign mdc_rise   = MDC & ~mdc_q_r;
	assign mdc_fall   = ~MDC & mdc_q_r;
	assign hdr        = {shift_r[10:0], MDIO_I};
	assign ovr_wr     = wr_commit_r & CMD_OVERRIDE;
	assign fault_rise = LINK_FAULT & ~fault_q_r;
	assign fault_fall = ~LINK_FAULT & fault_q_r;

	// Register as seen by the station; reserved and T4 positions read zero.
	always_comb begin
		adv_view                          = anadv_word_t'(16'h0000);
		adv_view.next_page                = np_r;
		adv_view.ack                      = 1'b0;
		adv_view.remote_fault             = rf_r;
		adv_view.rsv                      = 3'h0;
		adv_view.t4                       = 1'b0;
		adv_view.technology_ability_field = ability_r;
		adv_view.selector                 = sel_r;
	end

	// Negotiation is requested by the strap in hardware mode and by the
	// control register enable in software mode.
	always_comb begin
		if (MODE_SELECT_PIN_A) begin
			an_req = init_done_r & AN_ENABLE;
		end else begin
			an_req = init_done_r & AUTONEG_SELECT_PIN;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			mdc_q_r   <= 1'b0;
			fault_q_r <= 1'b0;
		end else begin
			mdc_q_r   <= MDC;
			fault_q_r <= LINK_FAULT;
		end
	end

	// Next-page flag: plain read/write.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			np_r <= 1'b0;
		end else if (wr_commit_r) begin
			np_r <= wr_data_r[NP_BIT];
		end
	end

	// Reserved bits are stored only under command override; they never
	// read back but feed the auxiliary functions they steer.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			rsv14_r <= 1'b0;
			rsv_r   <= 3'h0;
		end else if (ovr_wr) begin
			rsv14_r <= wr_data_r[RSV14_BIT];
			rsv_r   <= wr_data_r[RSV_HI_BIT:RSV_LO_BIT];
		end
	end

	// Remote fault follows the local fault detector's edges; a write may
	// set or clear it between edges. A detected fault beats a write.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			rf_r <= 1'b0;
		end else if (fault_rise) begin
			rf_r <= 1'b1;
		end else if (fault_fall) begin
			rf_r <= 1'b0;
		end else if (wr_commit_r) begin
			rf_r <= wr_data_r[RF_BIT];
		end
	end

	// Ability bits: pin driven and read-only in hardware mode,
	// override-write in software mode. With negotiation off in hardware
	// mode the value is unspecified, so the all-abilities default stays.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			ability_r <= ABIL_ALL;
		end else if (!MODE_SELECT_PIN_A) begin
			if (AUTONEG_SELECT_PIN) begin
				ability_r <= pin_ability;
			end else begin
				ability_r <= ABIL_ALL;
			end
		end else if (ovr_wr) begin
			ability_r <= wr_data_r[ABIL_HI_BIT:ABIL_LO_BIT];
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			sel_r <= SEL_DEF;
		end else if (ovr_wr) begin
			sel_r <= wr_data_r[SEL_HI_BIT:0];
		end
	end

	// One idle cycle after reset lets the strap-derived abilities settle
	// before the first capture.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			init_done_r <= 1'b0;
		end else begin
			init_done_r <= 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			an_on_r    <= 1'b0;
			an_start_r <= 1'b0;
		end else begin
			an_on_r    <= an_req;
			an_start_r <= an_req & (~an_on_r | AN_RESTART);
		end
	end

	// Forced operation: idles at the speed and duplex of the pins or of
	// the control register, whichever mode is selected.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			force_idle_r <= 1'b0;
			force_spd_r  <= 1'b0;
			force_dpx_r  <= 1'b0;
		end else if (MODE_SELECT_PIN_A) begin
			force_idle_r <= init_done_r & ~AN_ENABLE;
			force_spd_r  <= CTRL_SPEED_100;
			force_dpx_r  <= CTRL_DUPLEX_FULL;
		end else begin
			force_idle_r <= init_done_r & ~AUTONEG_SELECT_PIN;
			force_spd_r  <= SPEED_SELECT_PIN;
			force_dpx_r  <= DUPLEX_SELECT_PIN;
		end
	end

	// Status capabilities never track the advertisement.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			status_ab_r <= ABIL_ALL;
		end else begin
			status_ab_r <= ABIL_ALL;
		end
	end

	// Serial management frames. MDC is oversampled by MCLK, so MDC must
	// stay well below a quarter of MCLK. Input bits are taken on MDC
	// rising edges; read data changes on falling edges.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			mst_r       <= MS_PRE;
			cnt_r       <= 6'h00;
			shift_r     <= 16'h0000;
			rd_buf_r    <= 16'h0000;
			hit_r       <= 1'b0;
			rd_drive_r  <= 1'b0;
			mdio_o_r    <= 1'b0;
			mdio_oe_r   <= 1'b0;
			wr_commit_r <= 1'b0;
			wr_data_r   <= 16'h0000;
		end else begin
			wr_commit_r <= 1'b0;
			unique case (mst_r)
				MS_PRE: begin
					if (mdc_rise) begin
						if (MDIO_I) begin
							if (cnt_r != PRE_ONES) begin
								cnt_r <= cnt_r + 6'h01;
							end
						end else begin
							if (cnt_r == PRE_ONES) begin
								mst_r <= MS_START;
							end
							cnt_r <= 6'h00;
						end
					end
				end
				MS_START: begin
					if (mdc_rise) begin
						cnt_r <= 6'h00;
						mst_r <= MDIO_I ? MS_HDR : MS_PRE;
					end
				end
				MS_HDR: begin
					if (mdc_rise) begin
						shift_r <= {shift_r[14:0], MDIO_I};
						cnt_r   <= cnt_r + 6'h01;
						if (cnt_r == HDR_LAST) begin
							cnt_r <= 6'h00;
							hit_r <= (hdr[9:5] == PHY_ADDR) &&
								(hdr[4:0] == ADV_REG_ADDR);
							rd_drive_r <= (hdr[11:10] == OP_READ) &&
								(hdr[9:5] == PHY_ADDR) &&
								(hdr[4:0] == ADV_REG_ADDR);
							rd_buf_r <= 16'(adv_view);
							if ((hdr[11:10] == OP_READ) ||
								(hdr[11:10] == OP_WRITE)) begin
								mst_r <= MS_TA;
							end else begin
								mst_r <= MS_PRE;
							end
						end
					end
				end
				MS_TA: begin
					if (rd_drive_r) begin
						// Second turnaround bit is driven low.
						if (mdc_fall) begin
							cnt_r <= cnt_r + 6'h01;
							if (cnt_r == TA_LAST) begin
								mdio_oe_r <= 1'b1;
								mdio_o_r  <= 1'b0;
								cnt_r     <= 6'h00;
								mst_r     <= MS_DATA;
							end
						end
					end else if (mdc_rise) begin
						cnt_r <= cnt_r + 6'h01;
						if (cnt_r == TA_LAST) begin
							cnt_r <= 6'h00;
							mst_r <= MS_DATA;
						end
					end
				end
				MS_DATA: begin
					if (rd_drive_r) begin
						if (mdc_fall) begin
							if (cnt_r == DATA_BITS) begin
								mdio_oe_r  <= 1'b0;
								mdio_o_r   <= 1'b0;
								rd_drive_r <= 1'b0;
								cnt_r      <= 6'h00;
								mst_r      <= MS_PRE;
							end else begin
								mdio_o_r <= rd_buf_r[15];
								rd_buf_r <= {rd_buf_r[14:0], 1'b0};
								cnt_r    <= cnt_r + 6'h01;
							end
						end
					end else if (mdc_rise) begin
						shift_r <= {shift_r[14:0], MDIO_I};
						cnt_r   <= cnt_r + 6'h01;
						if (cnt_r == DATA_LAST) begin
							// Reads of this register take the drive
							// branch, so a hit here is always a write.
							wr_commit_r <= hit_r;
							wr_data_r   <= {shift_r[14:0], MDIO_I};
							cnt_r       <= 6'h00;
							mst_r       <= MS_PRE;
						end
					end
				end
			endcase
		end
	end

	anadv_lcw u_lcw (
		.clk         (MCLK),
		.rst_b       (RST_B),
		.speed_100   (SPEED_SELECT_PIN),
		.duplex_full (DUPLEX_SELECT_PIN),
		.start       (an_start_r),
		.adv         (adv_view),
		.pin_ability (pin_ability),
		.lcw_r       (LINK_CODE_WORD)
	);

	assign MDIO_O            = mdio_o_r;
	assign MDIO_OE           = mdio_oe_r;
	assign AN_ACTIVE         = an_on_r;
	assign AN_START          = an_start_r;
	assign FORCE_IDLE        = force_idle_r;
	assign FORCE_SPEED_100   = force_spd_r;
	assign FORCE_DUPLEX_FULL = force_dpx_r;
	assign RSV_AUX           = {rsv14_r, rsv_r};
	assign STATUS_ABILITY    = status_ab_r;

endmodule

// [tb/anadv_monitor.sv]
`timescale 1ns/10ps
module anadv_monitor import anadv_pkg::*; (
	input wire logic        MCLK,
	input wire logic        RST_B,
	input wire logic        MODE_SELECT_PIN_A,
	input wire logic        AUTONEG_SELECT_PIN,
	input wire logic        AN_ENABLE,
	input wire logic        AN_RESTART,
	input wire logic        CMD_OVERRIDE,
	input wire anadv_word_t LINK_CODE_WORD,
	input wire logic        AN_ACTIVE,
	input wire logic        AN_START,
	input wire logic        FORCE_IDLE,
	input wire logic [3:0]  RSV_AUX,
	input wire logic [3:0]  STATUS_ABILITY
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	// Four settled cycles cover the two-edge start-up latency.
	sequence s_sw_on;
		(MODE_SELECT_PIN_A && AN_ENABLE) [*4];
	endsequence
	sequence s_sw_off;
		(MODE_SELECT_PIN_A && !AN_ENABLE) [*4];
	endsequence
	sequence s_hw_on;
		(!MODE_SELECT_PIN_A && AUTONEG_SELECT_PIN) [*4];
	endsequence
	sequence s_hw_off;
		(!MODE_SELECT_PIN_A && !AUTONEG_SELECT_PIN) [*4];
	endsequence
	a_status_fixed: assert property (STATUS_ABILITY == 4'hF)
		else $error("status ability changed");
	a_word_zeros: assert property (LINK_CODE_WORD.t4 == 1'b0
		&& LINK_CODE_WORD.ack == 1'b0 && LINK_CODE_WORD.rsv == 3'h0)
		else $error("code word carries reserved ones");
	a_word_hold: assert property ($changed(LINK_CODE_WORD)
		|-> AN_START || $past(AN_START))
		else $error("code word changed without start");
	a_rsv_guard: assert property ($changed(RSV_AUX)
		|-> $past(CMD_OVERRIDE))
		else $error("reserved bits written without override");
	a_restart_go: assert property (AN_RESTART && AN_ACTIVE
		|-> ##[0:2] AN_START)
		else $error("restart did not start negotiation");
	a_sw_neg_on: assert property (s_sw_on |-> AN_ACTIVE && !FORCE_IDLE)
		else $error("negotiation inactive in software mode");
	a_sw_neg_off: assert property (s_sw_off |-> FORCE_IDLE && !AN_ACTIVE)
		else $error("negotiation not skipped in software mode");
	a_hw_neg_on: assert property (s_hw_on |-> AN_ACTIVE && !FORCE_IDLE)
		else $error("negotiation inactive in hardware mode");
	a_hw_neg_off: assert property (s_hw_off |-> FORCE_IDLE && !AN_ACTIVE)
		else $error("negotiation not skipped in hardware mode");
endmodule
bind anadv_top anadv_monitor u_mon (.*);

// [tb/anadv_sta.sv]
`timescale 1ns/10ps
module anadv_sta import anadv_pkg::*; (
	input  wire logic mclk,
	input  wire logic mdio,
	output logic      mdc,
	output logic      sta_o,
	output logic      sta_oe
);
	initial begin
		mdc = 1'b0;
		sta_o = 1'b1;
		sta_oe = 1'b0;
	end
	// Nine MCLK per bit keeps MDC above the eight-cycle minimum.
	task automatic send_bit(input logic oe, input logic b, output logic s);
		mdc <= 1'b0;
		sta_oe <= oe;
		sta_o <= b;
		repeat (4) @(negedge mclk);
		mdc <= 1'b1;
		repeat (5) @(negedge mclk);
		s = mdio;
	endtask
	task automatic frame(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] q);
		logic [63:0] f;
		logic        s;
		f = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
		for (int i = 63; i >= 0; i--) begin
			send_bit(op == OP_WRITE || i > 17, f[i], s);
			if (i < 16)
				q[i] = s;
		end
		mdc <= 1'b0;
		sta_oe <= 1'b0;
		repeat (4) @(negedge mclk);
	endtask
endmodule

// [tb/autoneg_advertisement_register_bench.sv]
`timescale 1ns/10ps
module autoneg_advertisement_register_bench import anadv_pkg::*; ;
	logic        MCLK = 1'b0;
	logic        RST_B = 1'b0;
	logic        MODE_SELECT_PIN_A = 1'b1;
	logic        AUTONEG_SELECT_PIN = 1'b0;
	logic        SPEED_SELECT_PIN = 1'b1;
	logic        DUPLEX_SELECT_PIN = 1'b1;
	logic        AN_ENABLE = 1'b1;
	logic        AN_RESTART = 1'b0;
	logic        CTRL_SPEED_100 = 1'b0;
	logic        CTRL_DUPLEX_FULL = 1'b0;
	logic        CMD_OVERRIDE = 1'b0;
	logic        LINK_FAULT = 1'b0;
	logic        MDC, MDIO_I, MDIO_O, MDIO_OE, sta_o, sta_oe;
	logic        AN_ACTIVE, AN_START, FORCE_IDLE;
	logic        FORCE_SPEED_100, FORCE_DUPLEX_FULL;
	logic [3:0]  RSV_AUX, STATUS_ABILITY, fl;
	anadv_word_t LINK_CODE_WORD;
	logic [15:0] q;
	int          fails = 0;
	int          total_checks = 0;
	always #25 MCLK = ~MCLK;
	// A released management line floats to its pull-up level.
	assign MDIO_I = MDIO_OE ? MDIO_O : (sta_oe ? sta_o : 1'b1);
	assign fl = {FORCE_IDLE, FORCE_SPEED_100, FORCE_DUPLEX_FULL, AN_ACTIVE};
	anadv_top u_dut (.*);
	anadv_sta u_sta (.mclk(MCLK), .mdio(MDIO_I), .mdc(MDC),
		.sta_o(sta_o), .sta_oe(sta_oe));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge MCLK);
	endtask
	task wr(input logic [4:0] ra, input logic [15:0] d);
		u_sta.frame(OP_WRITE, PHY_ADDR_DEF, ra, d, q);
	endtask
	task rd(input logic [4:0] ra);
		u_sta.frame(OP_READ, PHY_ADDR_DEF, ra, 16'h0000, q);
	endtask
	task restart;
		AN_RESTART = 1'b1;
		cyc(1);
		AN_RESTART = 1'b0;
		cyc(3);
	endtask
	task do_reset;
		RST_B = 1'b0;
		cyc(3);
		RST_B = 1'b1;
		cyc(3);
	endtask
	task t_reset;
		rd(ADV_REG_ADDR);
		chk(q, ADV_RESET);
		chk(LINK_CODE_WORD, ADV_RESET);
		chk({12'h000, STATUS_ABILITY}, 16'h000F);
	endtask
	task t_np;
		wr(ADV_REG_ADDR, 16'h8000);
		rd(ADV_REG_ADDR);
		chk(q, 16'h81E1);
	endtask
	task t_ovr;
		CMD_OVERRIDE = 1'b1;
		wr(ADV_REG_ADDR, 16'h5E21);
		rd(ADV_REG_ADDR);
		chk(q, 16'h0021);
		chk({12'h000, RSV_AUX}, 16'h000F);
		chk(LINK_CODE_WORD, ADV_RESET);
		restart();
		chk(LINK_CODE_WORD, 16'h0021);
		wr(ADV_REG_ADDR, 16'h11E1);
		chk({12'h000, RSV_AUX}, 16'h0004);
		wr(ADV_REG_ADDR, ADV_RESET);
		CMD_OVERRIDE = 1'b0;
		chk({12'h000, RSV_AUX}, 16'h0000);
	endtask
	task t_fault;
		LINK_FAULT = 1'b1;
		cyc(3);
		rd(ADV_REG_ADDR);
		chk(q, 16'h21E1);
		restart();
		chk(LINK_CODE_WORD, 16'h21E1);
		LINK_FAULT = 1'b0;
		cyc(3);
		rd(ADV_REG_ADDR);
		chk(q, ADV_RESET);
	endtask
	task t_unmap;
		CMD_OVERRIDE = 1'b1;
		wr(5'h05, 16'h0000);
		u_sta.frame(OP_WRITE, 5'h02, ADV_REG_ADDR, 16'h8000, q);
		rd(5'h05);
		chk(q, 16'hFFFF);
		rd(ADV_REG_ADDR);
		chk(q, ADV_RESET);
		CMD_OVERRIDE = 1'b0;
	endtask
	task t_hw;
		MODE_SELECT_PIN_A = 1'b0;
		AUTONEG_SELECT_PIN = 1'b1;
		for (int i = 0; i < 4; i++) begin
			{SPEED_SELECT_PIN, DUPLEX_SELECT_PIN} = 2'(i);
			cyc(3);
			rd(ADV_REG_ADDR);
			chk(q, {7'h00, 4'h1 << i, 5'h01});
		end
		CMD_OVERRIDE = 1'b1;
		wr(ADV_REG_ADDR, 16'h0001);
		rd(ADV_REG_ADDR);
		chk(q, 16'h0101);
		CMD_OVERRIDE = 1'b0;
		AUTONEG_SELECT_PIN = 1'b0;
		cyc(4);
		chk({12'h000, fl}, 16'h000E);
		rd(ADV_REG_ADDR);
		chk(q, ADV_RESET);
		AUTONEG_SELECT_PIN = 1'b1;
		cyc(4);
		chk(LINK_CODE_WORD, 16'h0101);
		chk({14'h0000, fl[3], fl[0]}, 16'h0001);
		MODE_SELECT_PIN_A = 1'b1;
		AUTONEG_SELECT_PIN = 1'b0;
		do_reset();
	endtask
	task t_sw_off;
		AN_ENABLE = 1'b0;
		CTRL_SPEED_100 = 1'b1;
		cyc(4);
		chk({12'h000, fl}, 16'h000C);
		CTRL_SPEED_100 = 1'b0;
		CTRL_DUPLEX_FULL = 1'b1;
		cyc(4);
		chk({12'h000, fl}, 16'h000A);
		AN_ENABLE = 1'b1;
		cyc(4);
		chk({14'h0000, fl[3], fl[0]}, 16'h0001);
		chk(LINK_CODE_WORD, ADV_RESET);
	endtask
	initial begin
		repeat (30000) @(posedge MCLK);
		fails++;
		end_of_test();
	end
	initial begin
		do_reset();
		t_reset();
		t_np();
		t_ovr();
		t_fault();
		t_unmap();
		t_hw();
		t_sw_off();
		end_of_test();
	end
endmodule
